// File: include/plcs_pkg.sv
// Purpose: shared constants and types of the power line status/irq bank
// Assumes: 250 MHz core clock, 32-bit Avalon-MM register slave
// Notes: register byte address is four times the register index
package plcs_pkg;

  // ----------------------------------------------------------------
  // clock and bit timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int BIT_SHORT_NS = 24000;
  localparam int BIT_LONG_NS = 30000;
  localparam int BIT_SHORT_CYC = BIT_SHORT_NS * CLK_MHZ / 1000;
  localparam int BIT_LONG_CYC = BIT_LONG_NS * CLK_MHZ / 1000;
  localparam int BIT_CNT_W = 13;
  localparam int ACT_OFF_BITS = 4;
  localparam int TX_TRAILER_BITS = 2000;
  localparam int RX_TRAILER_BITS = 16;

  // ----------------------------------------------------------------
  // register map (indices; byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_STATUS = 8'h15;
  localparam logic [7:0] IDX_IRQ = 8'h16;
  localparam logic [7:0] IDX_MASK = 8'h17;
  localparam int ADDR_W = 8;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] IRQ_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;

  // bit order is shared by status, irq and mask
  typedef struct packed {
    logic [1:0] rfu;
    logic tx_failure;
    logic tx_success;
    logic tx_running;
    logic rx_failure;
    logic fresh_frame;
    logic rx_activity;
  } plcs_flags_t;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_DATA,
    TX_TRAILER
  } plcs_tx_state_t;

endpackage

// File: verilog/plcs_status_irq.sv
// Purpose: power line link status flags, sticky irq flags and irq output
// Assumes: modem/framing logic runs on CORE_CLK_I; RX_LINE_VALID_I is a pin
// Notes: status and irq are read only; an irq read clears what it returned
`timescale 1ns/100ps

// Behaviour
// - tx failure flag sets on failed send, clears on each new send command
// - tx success flag sets on good send, clears on next send command
// - fresh frame flag sets on new frame, clears after id and both bytes read
// - rx activity flag drops during the post-amble, covers preamble and data
// - rx activity flag drops after four bit periods of no valid signal
// - rx activity flag rises within four bit periods of valid preamble
// - tx failure irq latches on rising edge of tx failure flag
// - tx success irq latches on rising edge of tx success flag
// - fresh frame irq latches on rising edge of fresh frame flag
// - rx activity irq latches on both edges of rx activity flag
// - per-source mask, 0 blocks and 1 passes the source to the irq pin
// - trailer: send 2000 low bits, accept frame after 16 low bits
module plcs_status_irq #(
  parameter int BIT_SHORT = plcs_pkg::BIT_SHORT_CYC,
  parameter int BIT_LONG = plcs_pkg::BIT_LONG_CYC
) (
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  input wire logic [plcs_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic TX_SEND_CMD_I,
  input wire logic TX_DATA_DONE_I,
  input wire logic TX_DATA_FAIL_I,
  input wire logic TRAILER_DISABLE_I,
  input wire logic BIT_UNIT_LONG_I,
  input wire logic RX_LINE_VALID_I,
  input wire logic RX_IN_TRAILER_I,
  input wire logic RX_FRAME_I,
  input wire logic RX_FAIL_I,
  input wire logic ACCESSORY_IDENTIFIER_REG_RD_I,
  input wire logic ACC_BYTE1_RD_I,
  input wire logic ACC_BYTE2_RD_I,
  output logic TX_TRAILER_LOW_O,
  output plcs_pkg::plcs_flags_t STATUS_O,
  output logic IRQ_O
);
  import plcs_pkg::*;

  // ----------------------------------------------------------------
  // pin synchroniser and bit-period enable
  // ----------------------------------------------------------------
  logic valid_meta_ff, valid_ff;
  logic [BIT_CNT_W-1:0] bit_cnt_ff;
  logic bit_tick;
  logic [BIT_CNT_W-1:0] bit_last;

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      valid_meta_ff <= 1'b0;
      valid_ff <= 1'b0;
    end else begin
      valid_meta_ff <= RX_LINE_VALID_I;
      valid_ff <= valid_meta_ff;
    end
  end

  assign bit_last = BIT_UNIT_LONG_I ? BIT_CNT_W'(BIT_LONG - 1) :
                    BIT_CNT_W'(BIT_SHORT - 1);
  assign bit_tick = (bit_cnt_ff >= bit_last);

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      bit_cnt_ff <= '0;
    end else if (bit_tick) begin
      bit_cnt_ff <= '0;
    end else begin
      bit_cnt_ff <= bit_cnt_ff + BIT_CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // transmit sequence
  // ----------------------------------------------------------------
  plcs_tx_state_t tx_state_ff;
  logic [10:0] tx_trl_cnt_ff;
  logic tx_fail_set, tx_ok_set, tx_trl_end;
  plcs_flags_t st_ff, prev_ff, irq_ff, mask_ff;

  assign tx_trl_end = (tx_state_ff == TX_TRAILER) && bit_tick &&
                      (tx_trl_cnt_ff == 11'(TX_TRAILER_BITS - 1));
  assign tx_fail_set = (tx_state_ff == TX_DATA) && TX_DATA_DONE_I &&
                       TX_DATA_FAIL_I;
  assign tx_ok_set = tx_trl_end || ((tx_state_ff == TX_DATA) &&
                     TX_DATA_DONE_I && !TX_DATA_FAIL_I && TRAILER_DISABLE_I);

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      tx_state_ff <= TX_IDLE;
      tx_trl_cnt_ff <= '0;
    end else begin
      case (tx_state_ff)
        TX_IDLE: begin
          if (TX_SEND_CMD_I) begin
            tx_state_ff <= TX_DATA;
          end
        end
        TX_DATA: begin
          tx_trl_cnt_ff <= '0;
          if (tx_fail_set || tx_ok_set) begin
            tx_state_ff <= TX_IDLE;
          end else if (TX_DATA_DONE_I) begin
            tx_state_ff <= TX_TRAILER;
          end
        end
        TX_TRAILER: begin
          if (tx_trl_end) begin
            tx_state_ff <= TX_IDLE;
          end else if (bit_tick) begin
            tx_trl_cnt_ff <= tx_trl_cnt_ff + 11'(1);
          end
        end
        default: begin
          tx_state_ff <= TX_IDLE;
        end
      endcase
    end
  end

  assign TX_TRAILER_LOW_O = (tx_state_ff == TX_TRAILER);

  // ----------------------------------------------------------------
  // receive activity and frame acceptance
  // ----------------------------------------------------------------
  logic [2:0] idle_bits_ff;
  logic [4:0] rx_low_cnt_ff;
  logic rx_pend_ff;
  logic frame_set;
  logic [2:0] rd_seen_ff;
  logic all_read;

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      idle_bits_ff <= '0;
    end else if (valid_ff && !RX_IN_TRAILER_I) begin
      idle_bits_ff <= '0;
    end else if (bit_tick && idle_bits_ff != 3'(ACT_OFF_BITS)) begin
      idle_bits_ff <= idle_bits_ff + 3'(1);
    end
  end

  // with the trailer enabled, a frame counts only once the receiver has seen a proper trailer
  assign frame_set = (RX_FRAME_I && TRAILER_DISABLE_I) ||
                     (rx_pend_ff && bit_tick && !valid_ff &&
                      rx_low_cnt_ff == 5'(RX_TRAILER_BITS - 1));

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rx_pend_ff <= 1'b0;
      rx_low_cnt_ff <= '0;
    end else if (RX_FRAME_I && !TRAILER_DISABLE_I) begin
      rx_pend_ff <= 1'b1;
      rx_low_cnt_ff <= '0;
    end else if (frame_set || RX_FAIL_I) begin
      rx_pend_ff <= 1'b0;
    end else if (rx_pend_ff && bit_tick) begin
      rx_low_cnt_ff <= valid_ff ? '0 : rx_low_cnt_ff + 5'(1);
    end
  end

  assign all_read = &(rd_seen_ff | {ACC_BYTE2_RD_I, ACC_BYTE1_RD_I,
                                    ACCESSORY_IDENTIFIER_REG_RD_I});

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rd_seen_ff <= '0;
    end else if (frame_set || all_read) begin
      rd_seen_ff <= '0;
    end else begin
      rd_seen_ff <= rd_seen_ff | {ACC_BYTE2_RD_I, ACC_BYTE1_RD_I,
                                  ACCESSORY_IDENTIFIER_REG_RD_I};
    end
  end

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic ack_ff;
  logic [7:0] rd_sel_ff;
  logic rd_acc, wr_acc, irq_rd;
  logic [5:0] reg_idx;

  assign reg_idx = AVS_ADDRESS_I[7:2];
  // one wait cycle: read data are captured then, side effects at accept
  assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !ack_ff;
  assign rd_acc = AVS_READ_I && ack_ff;
  assign wr_acc = AVS_WRITE_I && ack_ff;
  assign irq_rd = rd_acc && reg_idx == IDX_IRQ[5:0];

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (AVS_READ_I || AVS_WRITE_I) && !ack_ff;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rd_sel_ff <= '0;
    end else if (AVS_READ_I && !ack_ff) begin
      case (reg_idx)
        IDX_STATUS[5:0]: rd_sel_ff <= st_ff;
        IDX_IRQ[5:0]: rd_sel_ff <= irq_ff;
        IDX_MASK[5:0]: rd_sel_ff <= mask_ff;
        default: rd_sel_ff <= '0;
      endcase
    end
  end

  assign AVS_READDATA_O = {24'h000000, rd_sel_ff};

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      mask_ff <= MASK_RST;
    end else if (wr_acc && reg_idx == IDX_MASK[5:0] &&
                 AVS_BYTEENABLE_I[0]) begin
      mask_ff <= {2'b00, AVS_WRITEDATA_I[5:0]};
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      st_ff <= STATUS_RST;
    end else begin
      st_ff.rfu <= 2'b00;
      if (tx_fail_set) begin
        st_ff.tx_failure <= 1'b1;
      end else if (TX_SEND_CMD_I) begin
        st_ff.tx_failure <= 1'b0;
      end
      if (tx_ok_set) begin
        st_ff.tx_success <= 1'b1;
      end else if (TX_SEND_CMD_I) begin
        st_ff.tx_success <= 1'b0;
      end
      st_ff.tx_running <= (tx_state_ff != TX_IDLE);
      if (RX_FAIL_I) begin
        st_ff.rx_failure <= 1'b1;
      end else if (frame_set) begin
        st_ff.rx_failure <= 1'b0;
      end
      if (frame_set) begin
        st_ff.fresh_frame <= 1'b1;
      end else if (all_read) begin
        st_ff.fresh_frame <= 1'b0;
      end
      if (RX_IN_TRAILER_I) begin
        st_ff.rx_activity <= 1'b0;
      end else if (valid_ff && bit_tick) begin
        st_ff.rx_activity <= 1'b1;
      end else if (idle_bits_ff == 3'(ACT_OFF_BITS)) begin
        st_ff.rx_activity <= 1'b0;
      end
    end
  end

  assign STATUS_O = st_ff;

  // ----------------------------------------------------------------
  // interrupt flags: set beats the read clear
  // ----------------------------------------------------------------
  plcs_flags_t rise, fall, ev;

  assign rise = st_ff & ~prev_ff;
  assign fall = ~st_ff & prev_ff;
  assign ev = '{rfu: 2'b00,
                tx_failure: rise.tx_failure,
                tx_success: rise.tx_success,
                tx_running: rise.tx_running | fall.tx_running,
                rx_failure: rise.rx_failure,
                fresh_frame: rise.fresh_frame,
                rx_activity: rise.rx_activity | fall.rx_activity};

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      prev_ff <= STATUS_RST;
      irq_ff <= IRQ_RST;
    end else begin
      prev_ff <= st_ff;
      irq_ff <= (irq_ff & ~(irq_rd ? rd_sel_ff : 8'h00)) | ev;
    end
  end

  assign IRQ_O = |(irq_ff & mask_ff);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_txerr_clear: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    TX_SEND_CMD_I && tx_state_ff == TX_IDLE |=> !st_ff.tx_failure)
    else $error("tx failure flag not cleared by send");
  a_txok_set: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    tx_ok_set |=> st_ff.tx_success && !st_ff.tx_failure)
    else $error("tx success flag not set");
  a_fresh_clear: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    all_read && !frame_set |=> !st_ff.fresh_frame)
    else $error("fresh frame flag not cleared after reads");
  a_act_trailer: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    RX_IN_TRAILER_I |=> !st_ff.rx_activity)
    else $error("activity flag held in post-amble");
  a_act_idle: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    idle_bits_ff == 3'(ACT_OFF_BITS) && !valid_ff |=> !st_ff.rx_activity)
    else $error("activity flag kept after idle bits");
  a_act_rise: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    valid_ff && bit_tick && !RX_IN_TRAILER_I |=> st_ff.rx_activity)
    else $error("activity flag not raised");
  a_irq_edges: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    $changed(st_ff.rx_activity) |=> irq_ff.rx_activity)
    else $error("activity irq missed an edge");
  a_irq_rise: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    $rose(st_ff.tx_failure) |=> irq_ff.tx_failure && irq_ff.rfu == 2'b00)
    else $error("tx failure irq not latched");
  a_irq_fresh: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    $rose(st_ff.fresh_frame) |=> irq_ff.fresh_frame)
    else $error("fresh frame irq not latched");
  a_irq_pin: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    IRQ_O |-> |(irq_ff & mask_ff))
    else $error("irq pin high with no unmasked flag");
  a_trl_len: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    $fell(TX_TRAILER_LOW_O) |-> $past(tx_trl_cnt_ff) ==
    11'(TX_TRAILER_BITS - 1))
    else $error("trailer length wrong");
  a_run_flag: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    tx_state_ff == TX_TRAILER |=> st_ff.tx_running)
    else $error("tx running flag low during send");
  a_rxerr_set: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    RX_FAIL_I && !st_ff.rx_failure |=> st_ff.rx_failure ##1
    irq_ff.rx_failure)
    else $error("rx failure flag or irq not set");
  a_txok_irq: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    $rose(st_ff.tx_success) |=> irq_ff.tx_success)
    else $error("tx success irq not latched");

endmodule // plcs_status_irq

// File: sim/plcs_acc_model.sv
// Purpose: behavioural accessory driving the receive side of the link
// Assumes: framer outputs seen by the bank are modelled as level/pulse pins
// Notes: a released line carries no signal, so line valid reads low
`timescale 1ns/100ps
module plcs_acc_model #(
  parameter int BIT = 8
) (
  input wire logic clk_i,
  output logic line_valid_o,
  output logic in_trailer_o,
  output logic frame_o,
  output logic fail_o
);
  import plcs_pkg::*;
  initial begin
    line_valid_o = 1'h0;
    in_trailer_o = 1'h0;
    frame_o = 1'h0;
    fail_o = 1'h0;
  end
  // preamble and data: valid signal on the line for nb bit periods
  task automatic data(input int nb);
    @(posedge clk_i);
    line_valid_o <= 1'h1;
    repeat (nb * BIT) @(posedge clk_i);
  endtask
  task automatic trailer_on();
    frame_o <= 1'h1;
    line_valid_o <= 1'h0;
    in_trailer_o <= 1'h1;
    @(posedge clk_i);
    frame_o <= 1'h0;
  endtask
  // low bits close the frame; fewer would not be a valid trailer
  task automatic trailer_off();
    repeat (RX_TRAILER_BITS * BIT) @(posedge clk_i);
    in_trailer_o <= 1'h0;
  endtask
  task automatic release_line();
    line_valid_o <= 1'h0;
  endtask
  task automatic fail_pulse();
    fail_o <= 1'h1;
    @(posedge clk_i);
    fail_o <= 1'h0;
    @(posedge clk_i);
  endtask
endmodule // plcs_acc_model

// File: sim/plcs_status_irq_tb.sv
// Purpose: self-checking bench of the link status and irq bank
// Assumes: short bit period parameter, accessory model on receive pins
// Notes: irq reads clear what they return, so reads are expectations too
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, e); end end
module plcs_status_irq_tb;
  import plcs_pkg::*;
  localparam int BT = 8;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, send = 0, done = 0, fail = 0;
  logic tdis = 1, lng = 0, id_rd = 0, b1_rd = 0, b2_rd = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdat = 32'h0, rdata, rdat;
  logic [3:0] be = 4'h0;
  logic wait_o, low_o, irq_o, lv, ltr, lfr, lfl;
  plcs_flags_t st;
  logic [7:0] stv;
  int n_fail = 0, cmp_count = 0, n;
  assign stv = st;
  plcs_status_irq #(.BIT_SHORT(BT), .BIT_LONG(BT + 2)) u_dut (
    .CORE_CLK_I(clk), .RESETN_I(rst_n), .AVS_ADDRESS_I(addr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat),
    .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(wait_o), .TX_SEND_CMD_I(send),
    .TX_DATA_DONE_I(done), .TX_DATA_FAIL_I(fail),
    .TRAILER_DISABLE_I(tdis), .BIT_UNIT_LONG_I(lng),
    .RX_LINE_VALID_I(lv), .RX_IN_TRAILER_I(ltr), .RX_FRAME_I(lfr),
    .RX_FAIL_I(lfl), .ACCESSORY_IDENTIFIER_REG_RD_I(id_rd), .ACC_BYTE1_RD_I(b1_rd),
    .ACC_BYTE2_RD_I(b2_rd), .TX_TRAILER_LOW_O(low_o), .STATUS_O(st),
    .IRQ_O(irq_o));
  plcs_acc_model #(.BIT(BT)) u_acc (.clk_i(clk), .line_valid_o(lv),
    .in_trailer_o(ltr), .frame_o(lfr), .fail_o(lfl));
  initial begin
    forever #2 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic av(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] b);
    int k;
    k = 0;
    rd <= !w;
    wr <= w;
    addr <= a;
    wdat <= d;
    be <= b;
    // waitrequest is judged settled, mid-cycle, before the accept edge
    do begin
      @(negedge clk);
      k++;
    end while (wait_o !== 1'h0 && k < 20);
    if (k >= 20) begin
      n_fail++;
    end
    @(posedge clk);
    rdat = rdata;
    rd <= 1'h0;
    wr <= 1'h0;
    // one idle edge keeps the next request off this release
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    av(1'h0, a, 32'h0, 4'hF);
    `CHK(rdat, e)
  endtask
  task automatic pulse(input int s);
    case (s)
      0: send <= 1'h1;
      1: done <= 1'h1;
      2: id_rd <= 1'h1;
      3: b1_rd <= 1'h1;
      default: b2_rd <= 1'h1;
    endcase
    @(posedge clk);
    {send, done, id_rd, b1_rd, b2_rd} <= 5'h00;
    @(posedge clk);
  endtask
  task automatic wait_st(input int b, input logic v, input int lim);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (stv[b] !== v && n < lim);
    @(posedge clk);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    `CHK(stv, STATUS_RST)
    rdchk(8'h58, 32'h0);
    av(1'h1, 8'h54, 32'hFF, 4'hF);
    rdchk(8'h54, 32'h0);
    rdchk(8'h40, 32'h0);
    av(1'h1, 8'h5C, 32'h3F, 4'h0);
    rdchk(8'h5C, 32'h0);
    av(1'h1, 8'h5C, 32'h3F, 4'h1);
    rdchk(8'h5C, 32'h3F);
    $display("test regs done");
  endtask
  task automatic t_tx_fail();
    pulse(0);
    wait_st(3, 1'h1, 4);
    `CHK(st.tx_running, 1'h1)
    fail <= 1'h1;
    pulse(1);
    fail <= 1'h0;
    wait_st(5, 1'h1, 8);
    `CHK(st.tx_failure, 1'h1)
    wait_st(3, 1'h0, 4);
    repeat (2) @(posedge clk);
    `CHK(irq_o, 1'h1)
    rdchk(8'h58, 32'h28);
    `CHK(irq_o, 1'h0)
    $display("test tx_fail done");
  endtask
  task automatic t_tx_trailer();
    tdis <= 1'h0;
    pulse(0);
    wait_st(5, 1'h0, 4);
    `CHK(st.tx_failure, 1'h0)
    pulse(1);
    `CHK(low_o, 1'h1)
    wait_st(4, 1'h1, TX_TRAILER_BITS * BT + 20);
    `CHK(n >= (TX_TRAILER_BITS - 1) * BT, 1'h1)
    `CHK(st.tx_success, 1'h1)
    wait_st(3, 1'h0, 4);
    `CHK(low_o, 1'h0)
    repeat (2) @(posedge clk);
    rdchk(8'h58, 32'h18);
    tdis <= 1'h1;
    pulse(0);
    wait_st(4, 1'h0, 4);
    `CHK(st.tx_success, 1'h0)
    pulse(1);
    wait_st(3, 1'h0, 8);
    repeat (2) @(posedge clk);
    rdchk(8'h58, 32'h18);
    $display("test tx_trailer done");
  endtask
  task automatic t_rx();
    av(1'h1, 8'h5C, 32'h3B, 4'h1);
    u_acc.fail_pulse();
    wait_st(2, 1'h1, 4);
    `CHK(st.rx_failure, 1'h1)
    repeat (2) @(posedge clk);
    `CHK(irq_o, 1'h0)
    rdchk(8'h58, 32'h04);
    av(1'h1, 8'h5C, 32'h3F, 4'h1);
    u_acc.data(4);
    wait_st(0, 1'h1, 3);
    `CHK(st.rx_activity, 1'h1)
    u_acc.trailer_on();
    wait_st(0, 1'h0, 3);
    `CHK(st.rx_activity, 1'h0)
    u_acc.trailer_off();
    wait_st(1, 1'h1, 20 * BT);
    `CHK(st.fresh_frame, 1'h1)
    `CHK(st.rx_failure, 1'h0)
    rdchk(8'h58, 32'h03);
    pulse(3);
    pulse(2);
    `CHK(st.fresh_frame, 1'h1)
    pulse(4);
    wait_st(1, 1'h0, 4);
    `CHK(st.fresh_frame, 1'h0)
    $display("test rx_frame done");
  endtask
  task automatic t_rx_idle();
    lng <= 1'h1;
    u_acc.data(2);
    u_acc.release_line();
    wait_st(0, 1'h0, 6 * (BT + 2));
    `CHK(n > 3 * (BT + 2), 1'h1)
    lng <= 1'h0;
    `CHK(st.rx_activity, 1'h0)
    repeat (2) @(posedge clk);
    rdchk(8'h58, 32'h01);
    $display("test rx_idle done");
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #400000;
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    t_regs();
    t_tx_fail();
    t_tx_trailer();
    t_rx();
    t_rx_idle();
    stop_test();
  end
endmodule // plcs_status_irq_tb
